// File: inc/spm_pkg.sv
`default_nettype none
package spm_pkg;
  // ==========================================================
  // Clock and serial rates
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned MASTER_MAX_HZ = 1_050_000;
  localparam int unsigned SLAVE_MAX_HZ  = 2_100_000;
  // Least half period of the master clock, rounded up
  localparam int unsigned HALF_MIN_CYC  = (CLK_HZ + 2 * MASTER_MAX_HZ - 1) / (2 * MASTER_MAX_HZ);
  localparam logic [7:0]  HALF_MIN      = HALF_MIN_CYC[7:0];
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [4:0]  LAST_EDGE     = 5'h0f;
  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  // ==========================================================
  // Control fields
  localparam int unsigned CTRL_IRQ_EN_BIT = 7;
  localparam int unsigned CTRL_EN_BIT     = 6;
  localparam int unsigned CTRL_MASTER_BIT = 4;
  localparam int unsigned CTRL_CLOCK_POLARITY_BIT_BIT   = 3;
  localparam int unsigned CTRL_CLOCK_PHASE_BIT_BIT   = 2;
  localparam int unsigned CTRL_RATE_LSB   = 0;
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  // ==========================================================
  // Status fields
  localparam int unsigned STAT_DONE_BIT = 7;
  localparam int unsigned STAT_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int unsigned STAT_MODE_FAULT_FLAG_BIT = 4;
endpackage
`default_nettype wire

// File: logic/spm_port.sv
// Function
// R1: Only a master drives the serial clock; a slave takes it as input.
// R2: Each master load of the shift register yields exactly eight clock pulses.
// R3: Master and slave shift registers swap contents over one transfer.
// R4: One transfer-done flag marks completion; no separate empty or full flags.
// R5: MOSI is output as master and input as slave.
// R6: MOSI carries master to slave data, most significant bit first.
// R7: MISO is input as master, output as slave, MSB first.
// R8: A deselected slave leaves MISO undriven.
// R9: Polarity and phase bits select four clock and data relations.
// R10: Master presents each MOSI bit half a clock before slave samples.
// R11: Both ends must use the same polarity and phase mode.
// R12: MOSI becomes an output when firmware sets the master select bit.
// R13: Master bit rate at most 1.05 MHz, four selectable rates.
// R14: Slave accepts serial clocks up to 2.1 MHz.
// R15: Write collision flag reports data writes during a transfer.
// R16: Protection against two devices both acting as master.
// R17: Master seeing select low drops master and enable, sets mode fault.
// R18: Master holds slave select low from first edge past eighth cycle; not done here, select_n_in is an input only.
// R19: Master data write starts transfer; received byte goes to read buffer.
// R20: Interrupt when enabled and transfer done or mode fault is set.
// R21: Idle master holds the clock at the polarity level.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module spm_port (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        sck_in,
  output var  logic        sck_out,
  output var  logic        sck_oe,
  input  wire logic        mosi_in,
  output var  logic        mosi_out,
  output var  logic        mosi_oe,
  input  wire logic        miso_in,
  output var  logic        miso_out,
  output var  logic        miso_oe,
  input  wire logic        select_n_in,
  output var  logic        irq
);
  // ==========================================================
  // State
  typedef struct packed {
    logic        irq_en;
    logic        en;
    logic        master;
    logic        clock_polarity_bit;
    logic        clock_phase_bit;
    logic [1:0]  rate;
    logic        done;
    logic        write_collision_flag;
    logic        mode_fault_flag;
    logic        armed;
    logic [7:0]  sr;
    logic [7:0]  rbuf;
    logic        out_bit;
    logic [3:0]  bitcnt;
    logic        busy;
    logic [7:0]  half_cnt;
    logic [4:0]  edges;
    logic        sck_lvl;
    logic        sck_s1;
    logic        sck_s2;
    logic        sck_s3;
    logic        ss_s1;
    logic        ss_s2;
    logic        mosi_s1;
    logic        mosi_s2;
    logic        miso_s1;
    logic        miso_s2;
    logic        a_valid;
    logic        a_write;
    logic [7:0]  a_addr;
    logic [31:0] rdata;
    logic        readyout;
    logic        sck_oe;
    logic        mosi_oe;
    logic        miso_oe;
    logic        irq;
    logic [3:0]  leads;
  } spm_state_t;

  spm_state_t st_reg;
  spm_state_t st_next;

  // Half period in hclk cycles for the four master rates
  function automatic logic [7:0] half_period(input logic [1:0] rate);
    case (rate)
      2'h0:    half_period = spm_pkg::HALF_MIN;
      2'h1:    half_period = spm_pkg::HALF_MIN << 1;
      2'h2:    half_period = spm_pkg::HALF_MIN << 3;
      default: half_period = spm_pkg::HALF_MIN << 4;
    endcase
  endfunction

  logic edge_ev;
  logic lead;
  logic smp;
  logic in_bit;
  logic [7:0] shifted;

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    edge_ev = 1'b0;
    lead    = 1'b0;
    smp     = 1'b0;
    in_bit  = 1'b0;
    shifted = 8'h00;
    // R14: pins pass two flops; 20 MHz sampling covers slave rates
    st_next.sck_s1  = sck_in;
    st_next.sck_s2  = st_reg.sck_s1;
    st_next.sck_s3  = st_reg.sck_s2;
    st_next.ss_s1   = select_n_in;
    st_next.ss_s2   = st_reg.ss_s1;
    st_next.mosi_s1 = mosi_in;
    st_next.mosi_s2 = st_reg.mosi_s1;
    st_next.miso_s1 = miso_in;
    st_next.miso_s2 = st_reg.miso_s1;
    // ==========================================================
    // Bus address phase; zero wait states, always OKAY
    st_next.readyout = 1'b1;
    st_next.a_valid  = hsel && htrans[1] && hready;
    st_next.a_write  = hwrite;
    st_next.a_addr   = haddr[7:0];
    if (st_next.a_valid && !hwrite) begin
      case (haddr[7:0])
        spm_pkg::CTRL_OFF: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rdata[spm_pkg::CTRL_IRQ_EN_BIT] = st_reg.irq_en;
          st_next.rdata[spm_pkg::CTRL_EN_BIT]     = st_reg.en;
          st_next.rdata[spm_pkg::CTRL_MASTER_BIT] = st_reg.master;
          st_next.rdata[spm_pkg::CTRL_CLOCK_POLARITY_BIT_BIT]   = st_reg.clock_polarity_bit;
          st_next.rdata[spm_pkg::CTRL_CLOCK_PHASE_BIT_BIT]   = st_reg.clock_phase_bit;
          st_next.rdata[spm_pkg::CTRL_RATE_LSB +: 2] = st_reg.rate;
        end
        spm_pkg::STAT_OFF: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rdata[spm_pkg::STAT_DONE_BIT] = st_reg.done;
          st_next.rdata[spm_pkg::STAT_WRITE_COLLISION_FLAG_BIT] = st_reg.write_collision_flag;
          st_next.rdata[spm_pkg::STAT_MODE_FAULT_FLAG_BIT] = st_reg.mode_fault_flag;
          // Flags clear only after software has seen them
          if (st_reg.done || st_reg.write_collision_flag || st_reg.mode_fault_flag) begin
            st_next.armed = 1'b1;
          end
        end
        spm_pkg::DATA_OFF: begin
          st_next.rdata = {24'h00_0000, st_reg.rbuf};
          // R4: status read then data access clears done
          if (st_reg.armed) begin
            st_next.done  = 1'b0;
            st_next.write_collision_flag  = 1'b0;
            st_next.armed = 1'b0;
          end
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // ==========================================================
    // Bus data phase writes
    if (st_reg.a_valid && st_reg.a_write) begin
      case (st_reg.a_addr)
        spm_pkg::CTRL_OFF: begin
          st_next.irq_en = hwdata[spm_pkg::CTRL_IRQ_EN_BIT];
          st_next.en     = hwdata[spm_pkg::CTRL_EN_BIT];
          st_next.master = hwdata[spm_pkg::CTRL_MASTER_BIT];
          st_next.clock_polarity_bit   = hwdata[spm_pkg::CTRL_CLOCK_POLARITY_BIT_BIT];
          st_next.clock_phase_bit   = hwdata[spm_pkg::CTRL_CLOCK_PHASE_BIT_BIT];
          st_next.rate   = hwdata[spm_pkg::CTRL_RATE_LSB +: 2];
          if (st_reg.armed) begin
            st_next.mode_fault_flag  = 1'b0;
            st_next.armed = 1'b0;
          end
        end
        spm_pkg::DATA_OFF: begin
          if (st_reg.armed) begin
            st_next.done  = 1'b0;
            st_next.write_collision_flag  = 1'b0;
            st_next.armed = 1'b0;
          end
          // R15: writes during a transfer are refused and flagged
          if (st_reg.busy || st_reg.bitcnt != 4'h0
              || (!st_reg.master && !st_reg.ss_s2 && !st_reg.clock_phase_bit)) begin
            st_next.write_collision_flag = 1'b1;
          end else begin
            st_next.sr      = hwdata[7:0];
            st_next.out_bit = hwdata[7];
            // R19: master write starts the transfer
            if (st_reg.master && st_reg.en) begin
              st_next.busy     = 1'b1;
              st_next.half_cnt = half_period(st_reg.rate) - 8'h01;
              st_next.edges    = 5'h00;
              st_next.leads    = 4'h0;
            end
          end
        end
        default: ;
      endcase
    end
    // ==========================================================
    // Edge source
    if (st_reg.master && st_reg.busy) begin
      // R13: clock edges paced by the rate divider
      if (st_reg.half_cnt == 8'h00) begin
        st_next.half_cnt = half_period(st_reg.rate) - 8'h01;
        st_next.sck_lvl  = ~st_reg.sck_lvl;
        edge_ev          = 1'b1;
        lead             = st_reg.sck_lvl == st_reg.clock_polarity_bit;
        st_next.edges    = st_reg.edges + 5'h01;
        // R2: sixteen edges make eight pulses
        if (st_reg.edges == spm_pkg::LAST_EDGE) begin
          st_next.busy = 1'b0;
        end
        if (lead) begin
          st_next.leads = st_reg.leads + 4'h1;
        end
      end else begin
        st_next.half_cnt = st_reg.half_cnt - 8'h01;
      end
      in_bit = st_reg.miso_s2;
    end else if (!st_reg.master && st_reg.en && !st_reg.ss_s2) begin
      // R1: slave follows the incoming clock only
      edge_ev = st_reg.sck_s2 != st_reg.sck_s3;
      lead    = st_reg.sck_s3 == st_reg.clock_polarity_bit;
      in_bit  = st_reg.mosi_s2;
    end
    if (!st_reg.master && st_reg.ss_s2) begin
      st_next.bitcnt = 4'h0;
    end
    // R9: phase picks sample on leading or trailing edge
    // R11: one mode setting serves both roles
    smp     = edge_ev && (lead != st_reg.clock_phase_bit);
    // R6: MSB leaves first, LSB last
    shifted = {st_reg.sr[6:0], in_bit};
    if (smp) begin
      // R3: outgoing MSB leaves while partner bit enters
      st_next.sr     = shifted;
      st_next.bitcnt = st_reg.bitcnt + 4'h1;
      if (st_reg.bitcnt == spm_pkg::LAST_BIT) begin
        st_next.bitcnt = 4'h0;
        st_next.rbuf   = shifted;
        st_next.done   = 1'b1;
      end
    end else if (edge_ev) begin
      // R10: next bit shown half a clock before sampling
      st_next.out_bit = st_reg.sr[7];
    end
    if (!st_reg.master && !st_reg.clock_phase_bit && st_reg.bitcnt == 4'h0 && !edge_ev) begin
      st_next.out_bit = st_reg.sr[7];
    end
    // ==========================================================
    // R16: a second master is detected and this end steps back
    // R17: drop master and enable, set mode fault
    if (st_reg.master && st_reg.en && !st_reg.ss_s2) begin
      st_next.master = 1'b0;
      st_next.en     = 1'b0;
      st_next.mode_fault_flag   = 1'b1;
      st_next.busy   = 1'b0;
    end
    // R21: idle clock rests at the polarity level
    if (!st_reg.busy) begin
      st_next.sck_lvl = st_reg.clock_polarity_bit;
    end
    // R5: MOSI driven only as master
    // R12: master select turns MOSI into an output
    st_next.sck_oe  = st_next.en && st_next.master;
    st_next.mosi_oe = st_next.en && st_next.master;
    // R7: MISO driven only as selected slave
    // R8: deselected slave releases MISO
    st_next.miso_oe = st_next.en && !st_next.master && !st_reg.ss_s2;
    // R20: interrupt from done or mode fault
    st_next.irq = st_next.irq_en && (st_next.done || st_next.mode_fault_flag);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg          <= '0;
      st_reg.readyout <= 1'b1;
      st_reg.ss_s1    <= 1'b1;
      st_reg.ss_s2    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = st_reg.readyout;
  assign hresp     = 1'b0 & st_reg.readyout;
  assign hrdata    = st_reg.rdata;
  assign sck_out   = st_reg.sck_lvl;
  assign sck_oe    = st_reg.sck_oe;
  assign mosi_out  = st_reg.out_bit;
  assign mosi_oe   = st_reg.mosi_oe;
  assign miso_out  = st_reg.out_bit;
  assign miso_oe   = st_reg.miso_oe;
  assign irq       = st_reg.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_fault;
    st_reg.master && st_reg.en && !st_reg.ss_s2;
  endsequence

  sequence seq_cpu_data_wr;
    st_reg.a_valid && st_reg.a_write && st_reg.a_addr == spm_pkg::DATA_OFF;
  endsequence

  chk_slave_no_clock: assert property ( // R1
    sck_oe |-> $past(st_next.master) && st_reg.master)
    else $error("serial clock driven while not master");

  chk_eight_pulses: assert property ( // R2
    $fell(st_reg.busy) && st_reg.master |-> st_reg.leads == 4'h8)
    else $error("master byte did not give eight pulses");

  chk_done_after: assert property ( // R4
    $rose(st_reg.done) |-> st_reg.bitcnt == 4'h0 && $past(st_reg.bitcnt) == 4'h7)
    else $error("done flag not at eighth bit");

  chk_mosi_dir: assert property ( // R5
    !st_reg.master |-> !mosi_oe)
    else $error("MOSI driven outside master mode");

  chk_miso_hiz: assert property ( // R8
    st_reg.ss_s2 |=> !miso_oe)
    else $error("MISO driven while deselected");

  chk_idle_level: assert property ( // R21
    !$past(st_reg.busy) |-> sck_out == $past(st_reg.clock_polarity_bit))
    else $error("idle clock not at polarity level");

  chk_mode_fault: assert property ( // R17
    seq_fault |=> st_reg.mode_fault_flag && !st_reg.master && !st_reg.en ##1 !sck_oe && !mosi_oe)
    else $error("mode fault not taken");

  chk_write_coll: assert property ( // R15
    seq_cpu_data_wr and st_reg.busy |=> st_reg.write_collision_flag && ($stable(st_reg.sr) || $past(smp)))
    else $error("collision not flagged");

  chk_irq_out: assert property ( // R20
    st_reg.irq_en && (st_reg.done || st_reg.mode_fault_flag) && $stable(st_reg.irq_en)[*2] |-> irq)
    else $error("interrupt missing");

  chk_rate_floor: assert property ( // R13
    st_reg.busy && $changed(sck_out) |=> !$changed(sck_out) [*8])
    else $error("master clock too fast");
endmodule
`default_nettype wire

// File: tb/spm_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// Far side slave
module spm_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] sr,
  output var  int         edges
);
  initial begin
    miso = 1'b0;
    sr = 8'h00;
    edges = 0;
  end
  always @(negedge sel_n) begin
    sr = tx;
    edges = 0;
    if (!clock_phase_bit) begin
      miso = tx[7];
    end
  end
  // Released line shows inverse, so no stale bit passes
  always @(posedge sel_n) begin
    miso = ~miso;
  end
  always @(sck) begin
    if (!sel_n) begin
      edges++;
      if ((sck != clock_polarity_bit) ^ clock_phase_bit) begin
        sr = {sr[6:0], mosi};
      end else begin
        miso = sr[7];
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/spm_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s exp %h got %h", nm, ex, got); end end
module spm_port_tb_top;
  logic        hclk, hresetn, hsel, hwrite, tb_sck, tb_mosi, sel_n, psel, pol, pha;
  logic [31:0] haddr, hwdata, d, st;
  logic [1:0]  htrans;
  logic [7:0]  m, ptx, rx;
  wire logic        hreadyout, hresp, sck_out, sck_oe, mosi_out, mosi_oe;
  wire logic        miso_out, miso_oe, irq, p_miso;
  wire logic [31:0] hrdata;
  wire logic [7:0]  p_sr;
  int               p_edges, err_total, n_compared;
  wire logic sck_w  = sck_oe ? sck_out : tb_sck;
  wire logic mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire logic miso_w = miso_oe ? miso_out : p_miso;
  spm_port spm_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
    .select_n_in(sel_n), .irq(irq));
  spm_slave_model spm_slave_model_i (.sck(sck_w), .mosi(mosi_w), .sel_n(psel),
    .clock_polarity_bit(pol), .clock_phase_bit(pha), .tx(ptx), .miso(p_miso), .sr(p_sr), .edges(p_edges));
  // ====================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  // Polling the status read also arms the flag clear
  task automatic wait_done();
    st = 32'h0;
    for (int i = 0; i < 2000 && st[7] !== 1'b1; i++) begin
      rd(spm_pkg::STAT_OFF, st);
    end
  endtask
  // Bench as master, 400 ns link period
  task automatic s_xfer(input logic [7:0] tx, output logic [7:0] r);
    tb_mosi <= tx[7];
    sel_n <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("miso_oe sel", 1'b1, miso_oe)
    for (int k = 7; k >= 0; k--) begin
      repeat (4) @(posedge hclk);
      tb_sck <= ~pol;
      if (pha) tb_mosi <= tx[k];
      else r[k] = miso_w;
      repeat (4) @(posedge hclk);
      tb_sck <= pol;
      if (pha) r[k] = miso_w;
      else if (k > 0) tb_mosi <= tx[k-1];
    end
    repeat (8) @(posedge hclk);
    sel_n <= 1'b1;
  endtask
  task automatic summarize();
    $display("counts compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Run needs about 6000 cycles
  initial begin
    #1_000_000;
    err_total++;
    summarize();
  end
  initial begin
    {hresetn, hsel, hwrite, tb_sck, tb_mosi, pol, pha} = '0;
    {sel_n, psel} = 2'b11;
    {haddr, hwdata, htrans, ptx, rx, err_total, n_compared} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(spm_pkg::CTRL_OFF, d);
    `CHK("ctrl rst", 32'h0, d)
    `CHK("hresp", 1'b0, hresp)
    rd(8'h40, d);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
    for (m = 0; m < 4; m++) begin
      {pol, pha} = m[1:0];
      ptx = 8'h5a - m;
      wr(spm_pkg::CTRL_OFF, 8'h50 | (m << 2) | m);
      // Let the clock settle at the new polarity before selecting
      repeat (2) @(posedge hclk);
      psel <= 1'b0;
      wr(spm_pkg::DATA_OFF, 8'h96 + m);
      `CHK("sck_oe", 1'b1, sck_oe)
      `CHK("mosi_oe", 1'b1, mosi_oe)
      wait_done();
      // Phase 0 ends half a clock after done; slowest half is 160
      repeat (170) @(posedge hclk);
      `CHK("status", 32'h80, st)
      `CHK("edges", 16, p_edges)
      `CHK("far rx", 8'h96 + m, p_sr)
      rd(spm_pkg::DATA_OFF, d);
      `CHK("rbuf", {24'h0, ptx}, d)
      `CHK("sck idle", pol, sck_w)
      psel <= 1'b1;
    end
    $display("test master modes done");
    {pol, pha} = 2'b00;
    ptx = 8'hc3;
    wr(spm_pkg::CTRL_OFF, 8'hd0);
    repeat (2) @(posedge hclk);
    psel <= 1'b0;
    wr(spm_pkg::DATA_OFF, 8'h11);
    wr(spm_pkg::DATA_OFF, 8'h22);
    wait_done();
    `CHK("write_collision_flag", 32'hc0, st)
    `CHK("irq set", 1'b1, irq)
    `CHK("no reload", 8'h11, p_sr)
    rd(spm_pkg::DATA_OFF, d);
    repeat (2) @(posedge hclk);
    `CHK("irq clr", 1'b0, irq)
    psel <= 1'b1;
    $display("test collision done");
    wr(spm_pkg::CTRL_OFF, 8'h50);
    sel_n <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("sck rel", 1'b0, sck_oe)
    `CHK("mosi rel", 1'b0, mosi_oe)
    rd(spm_pkg::STAT_OFF, d);
    `CHK("mode_fault_flag", 32'h10, d)
    rd(spm_pkg::CTRL_OFF, d);
    `CHK("ctrl fault", 32'h0, d)
    sel_n <= 1'b1;
    wr(spm_pkg::CTRL_OFF, 8'h00);
    rd(spm_pkg::STAT_OFF, d);
    `CHK("mode_fault_flag clr", 32'h0, d)
    $display("test mode fault done");
    for (m = 0; m < 4; m++) begin
      {pol, pha} = m[1:0];
      wr(spm_pkg::CTRL_OFF, 8'h40 | (m << 2));
      tb_sck <= pol;
      wr(spm_pkg::DATA_OFF, 8'h69 + m);
      `CHK("miso hiz", 1'b0, miso_oe)
      `CHK("slave sck", 1'b0, sck_oe)
      `CHK("slave mosi", 1'b0, mosi_oe)
      s_xfer(8'hb4 - m, rx);
      `CHK("slave tx", 8'h69 + m, rx)
      wait_done();
      rd(spm_pkg::DATA_OFF, d);
      `CHK("slave rx", {24'h0, 8'hb4 - m}, d)
    end
    $display("test slave modes done");
    summarize();
  end
endmodule
`default_nettype wire
